/* File: hdl/pmhr_fifo.sv */
`timescale 1ns/1ps
module pmhr_fifo #(
  parameter int WIDTH = 6,
  parameter int DEPTH = 16
) (
  input  wire logic             mclk_in,
  input  wire logic             nrst_in,
  input  wire logic             clk_en_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic      [WIDTH-1:0] out_data_out
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_reg [0:DEPTH-1];
  logic [AW:0]      wr_ptr_reg;
  logic [AW:0]      rd_ptr_reg;
  logic             full;
  logic             empty;

  assign empty = (wr_ptr_reg == rd_ptr_reg);
  assign full = (wr_ptr_reg[AW] != rd_ptr_reg[AW]) &&
                (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
  assign in_ready_out = !full;
  assign out_valid_out = !empty;
  assign out_data_out = mem_reg[rd_ptr_reg[AW-1:0]];

  always_ff @(posedge mclk_in)
  begin
    if (clk_en_in && in_valid_in && !full)
      mem_reg[wr_ptr_reg[AW-1:0]] <= in_data_in;
  end

  always_ff @(posedge mclk_in)
  begin
    if (!nrst_in)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end
    else if (clk_en_in)
    begin
      if (in_valid_in && !full)
        wr_ptr_reg <= wr_ptr_reg + {{AW{1'b0}}, 1'b1};
      if (out_ready_in && !empty)
        rd_ptr_reg <= rd_ptr_reg + {{AW{1'b0}}, 1'b1};
    end
  end
endmodule : pmhr_fifo

/* File: hdl/pmhr_pkg.sv */
package pmhr_pkg;

  localparam int SYM_W = 6;
  localparam int NUM_RX = 63;
  localparam int NUM_SYN = 16;
  localparam int NUM_TX = 47;
  localparam int NUM_BLK = NUM_TX + NUM_SYN;
  localparam int FIFO_DEPTH = 16;

  localparam logic [6:0] ADDR_SYN_BASE = 7'h3f;
  localparam logic [6:0] ADDR_STATUS = 7'h4f;
  localparam logic [6:0] ADDR_FLAGS = 7'h50;
  localparam logic [6:0] ADDR_TX_LAST = 7'h2e;
  localparam logic [6:0] ADDR_TIMER = 7'h2f;
  localparam logic [6:0] ADDR_CONTROL = 7'h30;
  localparam logic [6:0] ADDR_MASK = 7'h31;

  // status, flag, mask and control bit positions
  localparam int ST_SYNC = 7;
  localparam int ST_DEC = 6;
  localparam int ST_IDLE = 5;
  localparam int ST_ERR = 4;
  localparam int FL_SYNC = 7;
  localparam int FL_DEC = 6;
  localparam int FL_IDLE = 5;
  localparam int FL_TX = 4;
  localparam int FL_TIME = 3;
  localparam int MK_ERR = 2;
  localparam int CT_ACQ = 7;
  localparam int CT_HOLD = 6;
  localparam int CT_RECEIVER_POWERSAVE = 5;
  localparam int CT_TRANSMITTER_POWERSAVE = 4;
  localparam int CT_CI = 3;

  localparam logic [7:0] CONTROL_RST = 8'h30;
  localparam logic [7:0] MASK_RST = 8'h00;

  localparam int SYNC_LOSS_BITS = 420;
  localparam int SECOND_S = 1;
  localparam int CLK_PERIOD_NS = 10;
  localparam int SECOND_CYCLES = SECOND_S * 1000000000 / CLK_PERIOD_NS;

  localparam logic [6:0] PRIM_POLY = 7'h43;

  function automatic logic [5:0] gf_mul(input logic [5:0] a,
                                        input logic [5:0] b);
    logic [5:0] p;
    logic [5:0] x;
    p = 6'h00;
    x = a;
    for (int i = 0; i < SYM_W; i++)
    begin
      if (b[i])
        p = p ^ x;
      x = {x[4:0], 1'b0} ^ (x[5] ? PRIM_POLY[5:0] : 6'h00);
    end
    return p;
  endfunction : gf_mul

  function automatic logic [5:0] gf_alpha(input int n);
    logic [5:0] x;
    x = 6'h01;
    for (int i = 0; i < n; i++)
      x = gf_mul(x, 6'h02);
    return x;
  endfunction : gf_alpha

  function automatic logic [5:0] gen_coef(input int k);
    logic [5:0] g [0:NUM_SYN];
    for (int j = 0; j <= NUM_SYN; j++)
      g[j] = 6'h00;
    g[0] = 6'h01;
    for (int i = 1; i <= NUM_SYN; i++)
    begin
      for (int j = i; j > 0; j--)
        g[j] = g[j-1] ^ gf_mul(g[j], gf_alpha(i));
      g[0] = gf_mul(g[0], gf_alpha(i));
    end
    return g[k];
  endfunction : gen_coef

endpackage : pmhr_pkg

/* File: hdl/pmhr_top.sv */
`timescale 1ns/1ps
module pmhr_top
  import pmhr_pkg::*;
#(
  parameter int SEC_CYCLES = SECOND_CYCLES
) (
  input  wire logic       mclk_in,
  input  wire logic       nrst_in,
  input  wire logic       clk_en_in,
  input  wire logic [6:0] address_in,
  input  wire logic [7:0] data_in,
  output logic      [7:0] data_out,
  output logic            data_oe_out,
  input  wire logic       read_strobe_n_in,
  input  wire logic       write_strobe_n_in,
  input  wire logic       chip_select_n_in,
  output logic            interrupt_request_n_out,
  input  wire logic       rx_sym_valid_in,
  output logic            rx_sym_ready_out,
  input  wire logic [5:0] rx_sym_data_in,
  input  wire logic       sync_word_in,
  input  wire logic [2:0] sync_err_count_in,
  input  wire logic       bit_tick_in,
  input  wire logic       decode_bit_valid_in,
  input  wire logic       decode_fail_in,
  input  wire logic       idle_bit_valid_in,
  input  wire logic       idle_bit_in,
  output logic            tx_sym_valid_out,
  input  wire logic       tx_sym_ready_in,
  output logic      [5:0] tx_sym_data_out,
  output logic            fast_acquire_out,
  output logic            rx_hold_out,
  output logic            receiver_powersave_out,
  output logic            transmitter_powersave_out,
  output logic            continuation_indicator_out
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations
  logic [5:0] rx_reg      [0:NUM_RX-1];
  logic [5:0] rx_shd_reg  [0:NUM_RX-1];
  logic [5:0] syn_reg     [0:NUM_SYN-1];
  logic [5:0] syn_acc_reg [0:NUM_SYN-1];
  logic [5:0] syn_next    [0:NUM_SYN-1];
  logic [5:0] tx_in_reg   [0:NUM_TX-1];
  logic [5:0] tx_out_reg  [0:NUM_TX-1];
  logic [5:0] par_reg     [0:NUM_SYN-1];
  logic [5:0] par_next    [0:NUM_SYN-1];
  logic [7:0] control_reg;
  logic [7:0] mask_reg;
  logic [7:0] flags_reg;
  logic [7:0] flags_set;
  logic [7:0] data_reg;
  logic [7:0] status;
  logic [6:0] syn_idx;
  logic [5:0] rx_cnt_reg;
  logic [5:0] tx_idx_reg;
  logic [5:0] fifo_data;
  logic [5:0] fb;
  logic [4:0] hist_reg;
  logic [4:0] hist_next;
  logic [2:0] serr_reg;
  logic [8:0] bits_reg;
  logic [7:0] sec_reg;
  logic [31:0] pre_reg;
  logic       sync_reg;
  logic       dec_reg;
  logic       idle_reg;
  logic       err_reg;
  logic       rd_act;
  logic       wr_act;
  logic       wr_act_reg;
  logic       wr_pulse;
  logic       rd_flags_reg;
  logic       clr_flags;
  logic       fifo_valid;
  logic       drain;
  logic       accept;
  logic       lost;
  logic       receiver_powersave_init;
  logic       transmitter_powersave_init;
  logic       syn_nz;
  logic       tx_loaded_reg;
  logic       tx_run_reg;
  logic       tx_take;
  logic       tx_copy;
  logic       tmr_on_reg;
  logic       expire;
  logic       irq_reg;

  function automatic logic maj5(input logic [4:0] v);
    return (({2'b00, v[0]} + {2'b00, v[1]} + {2'b00, v[2]} +
             {2'b00, v[3]} + {2'b00, v[4]}) >= 3'd3);
  endfunction : maj5

  ////////////////////////////////////////////////////////////////////////////
  // host bus
  assign rd_act = !chip_select_n_in && !read_strobe_n_in;
  assign wr_act = !chip_select_n_in && !write_strobe_n_in;
  assign wr_pulse = wr_act && !wr_act_reg;
  assign clr_flags = rd_flags_reg && !rd_act;
  assign syn_idx = address_in - ADDR_SYN_BASE;
  assign data_out = data_reg;
  assign data_oe_out = rd_act;
  assign status = {sync_reg, dec_reg, idle_reg, err_reg, 1'b0, serr_reg};
  assign receiver_powersave_init = wr_pulse && address_in == ADDR_CONTROL &&
                     data_in[CT_RECEIVER_POWERSAVE];
  assign transmitter_powersave_init = wr_pulse && address_in == ADDR_CONTROL &&
                     data_in[CT_TRANSMITTER_POWERSAVE];

  always_ff @(posedge mclk_in)
  begin
    if (!nrst_in)
    begin
      wr_act_reg <= 1'b0;
      rd_flags_reg <= 1'b0;
      data_reg <= 8'h00;
    end
    else if (clk_en_in)
    begin
      wr_act_reg <= wr_act;
      rd_flags_reg <= rd_act && address_in == ADDR_FLAGS;
      if (rd_act)
      begin
        if (address_in < ADDR_SYN_BASE)
          data_reg <= {2'b00, rx_reg[address_in[5:0]]};
        else if (address_in < ADDR_STATUS)
          data_reg <= {2'b00, syn_reg[syn_idx[3:0]]};
        else if (address_in == ADDR_STATUS)
          data_reg <= status;
        else if (address_in == ADDR_FLAGS)
          data_reg <= flags_reg;
        else
          data_reg <= 8'h00;
      end
    end
  end

  always_ff @(posedge mclk_in)
  begin
    if (!nrst_in)
    begin
      control_reg <= CONTROL_RST;
      mask_reg <= MASK_RST;
    end
    else if (clk_en_in && wr_pulse)
    begin
      if (address_in == ADDR_CONTROL)
        control_reg <= data_in;
      if (address_in == ADDR_MASK)
        mask_reg <= {data_in[7:2], 2'b00};
    end
  end

  assign fast_acquire_out = control_reg[CT_ACQ];
  assign rx_hold_out = control_reg[CT_HOLD];
  assign receiver_powersave_out = control_reg[CT_RECEIVER_POWERSAVE];
  assign transmitter_powersave_out = control_reg[CT_TRANSMITTER_POWERSAVE];
  assign continuation_indicator_out = control_reg[CT_CI];

  ////////////////////////////////////////////////////////////////////////////
  // receive symbols and syndromes
  pmhr_fifo #(
    .WIDTH (SYM_W),
    .DEPTH (FIFO_DEPTH)
  ) u_rx_fifo (
    .mclk_in       (mclk_in),
    .nrst_in       (nrst_in),
    .clk_en_in     (clk_en_in),
    .in_valid_in   (rx_sym_valid_in),
    .in_ready_out  (rx_sym_ready_out),
    .in_data_in    (rx_sym_data_in),
    .out_valid_out (fifo_valid),
    .out_ready_in  (drain),
    .out_data_out  (fifo_data)
  );

  // drain stalls once a full block waits for its sync word
  assign drain = rx_cnt_reg < 6'(NUM_RX) && !accept;
  assign accept = sync_word_in && !control_reg[CT_RECEIVER_POWERSAVE] &&
                  sync_err_count_in <= control_reg[2:0];

  genvar gi;
  generate
    for (gi = 0; gi < NUM_SYN; gi++)
    begin : g_syn
      assign syn_next[gi] = gf_mul(syn_acc_reg[gi], gf_alpha(gi + 1)) ^
                            fifo_data;
    end
  endgenerate

  always_comb
  begin
    syn_nz = 1'b0;
    for (int i = 0; i < NUM_SYN; i++)
      syn_nz = syn_nz | (|syn_acc_reg[i]);
  end

  always_ff @(posedge mclk_in)
  begin
    if (!nrst_in)
    begin
      rx_cnt_reg <= 6'h00;
      for (int i = 0; i < NUM_SYN; i++)
        syn_acc_reg[i] <= 6'h00;
    end
    else if (clk_en_in)
    begin
      if (accept)
      begin
        rx_cnt_reg <= 6'h00;
        for (int i = 0; i < NUM_SYN; i++)
          syn_acc_reg[i] <= 6'h00;
      end
      else if (drain && fifo_valid)
      begin
        rx_shd_reg[rx_cnt_reg] <= fifo_data;
        rx_cnt_reg <= rx_cnt_reg + 6'h01;
        syn_acc_reg <= syn_next;
      end
    end
  end

  always_ff @(posedge mclk_in)
  begin
    if (clk_en_in && accept)
    begin
      rx_reg <= rx_shd_reg;
      syn_reg <= syn_acc_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status
  assign lost = sync_reg && bit_tick_in &&
                bits_reg == 9'(SYNC_LOSS_BITS);
  assign hist_next = {hist_reg[3:0], idle_bit_in};

  always_ff @(posedge mclk_in)
  begin
    if (!nrst_in)
    begin
      sync_reg <= 1'b0;
      dec_reg <= 1'b0;
      idle_reg <= 1'b0;
      err_reg <= 1'b0;
      serr_reg <= 3'h0;
      bits_reg <= 9'h000;
      hist_reg <= 5'h00;
    end
    else if (clk_en_in)
    begin
      if (idle_bit_valid_in)
        hist_reg <= hist_next;
      if (receiver_powersave_init)
      begin
        sync_reg <= 1'b0;
        dec_reg <= 1'b0;
        idle_reg <= 1'b0;
        err_reg <= 1'b0;
        serr_reg <= 3'h0;
      end
      else
      begin
        if (accept)
        begin
          sync_reg <= 1'b1;
          serr_reg <= sync_err_count_in;
          err_reg <= syn_nz;
          bits_reg <= 9'h000;
          if (!sync_reg)
            idle_reg <= hist_reg[0];
        end
        else if (lost)
          sync_reg <= 1'b0;
        else if (sync_reg && bit_tick_in)
          bits_reg <= bits_reg + 9'h001;
        if (sync_reg && decode_bit_valid_in)
          dec_reg <= decode_fail_in;
        if (sync_reg && idle_bit_valid_in && !accept)
          idle_reg <= maj5(hist_next);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // transmit double buffer and parity
  assign tx_take = tx_run_reg && tx_sym_ready_in;
  assign tx_copy = !control_reg[CT_TRANSMITTER_POWERSAVE] && tx_loaded_reg &&
                   (!tx_run_reg ||
                    (tx_take && tx_idx_reg == 6'(NUM_BLK - 1)));
  assign tx_sym_valid_out = tx_run_reg;
  assign tx_sym_data_out = (tx_idx_reg < 6'(NUM_TX)) ?
                           tx_out_reg[tx_idx_reg] : par_reg[NUM_SYN-1];
  assign fb = tx_out_reg[tx_idx_reg] ^ par_reg[NUM_SYN-1];

  generate
    for (gi = 0; gi < NUM_SYN; gi++)
    begin : g_par
      if (gi == 0)
      begin : g_lo
        assign par_next[gi] = gf_mul(fb, gen_coef(gi));
      end
      else
      begin : g_hi
        assign par_next[gi] = par_reg[gi-1] ^ gf_mul(fb, gen_coef(gi));
      end
    end
  endgenerate

  always_ff @(posedge mclk_in)
  begin
    if (clk_en_in && wr_pulse && address_in <= ADDR_TX_LAST)
      tx_in_reg[address_in[5:0]] <= data_in[5:0];
    if (clk_en_in && tx_copy)
      tx_out_reg <= tx_in_reg;
  end

  always_ff @(posedge mclk_in)
  begin
    if (!nrst_in)
    begin
      tx_loaded_reg <= 1'b0;
      tx_run_reg <= 1'b0;
      tx_idx_reg <= 6'h00;
      for (int i = 0; i < NUM_SYN; i++)
        par_reg[i] <= 6'h00;
    end
    else if (clk_en_in)
    begin
      if (wr_pulse && address_in == ADDR_TX_LAST)
        tx_loaded_reg <= 1'b1;
      else if (tx_copy)
        tx_loaded_reg <= 1'b0;
      if (control_reg[CT_TRANSMITTER_POWERSAVE])
      begin
        tx_run_reg <= 1'b0;
        tx_idx_reg <= 6'h00;
        for (int i = 0; i < NUM_SYN; i++)
          par_reg[i] <= 6'h00;
      end
      else if (tx_copy && !tx_run_reg)
        tx_run_reg <= 1'b1;
      else if (tx_take)
      begin
        if (tx_idx_reg == 6'(NUM_BLK - 1))
        begin
          tx_idx_reg <= 6'h00;
          for (int i = 0; i < NUM_SYN; i++)
            par_reg[i] <= 6'h00;
        end
        else
        begin
          tx_idx_reg <= tx_idx_reg + 6'h01;
          if (tx_idx_reg < 6'(NUM_TX))
            par_reg <= par_next;
          else
          begin
            par_reg[0] <= 6'h00;
            for (int i = 1; i < NUM_SYN; i++)
              par_reg[i] <= par_reg[i-1];
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // one-shot timer
  assign expire = tmr_on_reg && pre_reg == 32'(SEC_CYCLES - 1) &&
                  sec_reg == 8'h01;

  always_ff @(posedge mclk_in)
  begin
    if (!nrst_in)
    begin
      tmr_on_reg <= 1'b0;
      sec_reg <= 8'h00;
      pre_reg <= 32'h00000000;
    end
    else if (clk_en_in)
    begin
      if (wr_pulse && address_in == ADDR_TIMER)
      begin
        sec_reg <= data_in;
        pre_reg <= 32'h00000000;
        tmr_on_reg <= |data_in;
      end
      else if (tmr_on_reg)
      begin
        if (pre_reg == 32'(SEC_CYCLES - 1))
        begin
          pre_reg <= 32'h00000000;
          sec_reg <= sec_reg - 8'h01;
          if (expire)
            tmr_on_reg <= 1'b0;
        end
        else
          pre_reg <= pre_reg + 32'h00000001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt flags
  always_comb
  begin
    flags_set = 8'h00;
    flags_set[FL_SYNC] = accept || lost;
    flags_set[FL_DEC] = sync_reg && decode_bit_valid_in &&
                        decode_fail_in != dec_reg;
    flags_set[FL_IDLE] = (accept && !sync_reg) ||
                         (sync_reg && idle_bit_valid_in && !accept &&
                          maj5(hist_next) != idle_reg);
    flags_set[FL_TX] = tx_copy || transmitter_powersave_init;
    flags_set[FL_TIME] = expire;
  end

  always_ff @(posedge mclk_in)
  begin
    if (!nrst_in)
      flags_reg <= 8'h00;
    else if (clk_en_in)
    begin
      // flags the host has read, and the receive flags on a receiver powersave write, are cleared; a late set survives
      flags_reg <= (flags_reg & ~(clr_flags ? (data_reg & 8'hf8) : 8'h00) &
                    ~(receiver_powersave_init ? 8'he0 : 8'h00)) | flags_set;
    end
  end

  // errored blocks may hold back the receive events
  always_ff @(posedge mclk_in)
  begin
    if (!nrst_in)
      irq_reg <= 1'b0;
    else if (clk_en_in)
      irq_reg <= |(flags_reg[7:3] & mask_reg[7:3] &
                   {{3{mask_reg[MK_ERR] || !err_reg}}, 2'b11});
  end

  assign interrupt_request_n_out = !irq_reg;

endmodule : pmhr_top

/* File: verification/packet_modem_host_registers_tb.sv */
`timescale 1ns/1ps
module packet_modem_host_registers_tb
  import pmhr_pkg::*;
;
  logic       mclk_in, nrst_in, rd_n, wr_n, cs_n, irq_n, rxv, rxr, sw;
  logic       tick, dv, df, iv, ib, txv, txr, err;
  logic [6:0] a;
  logic [7:0] wd, rdat, v;
  logic [5:0] rxd, txd;
  logic [2:0] sec;
  logic [5:0] rxq[$];
  logic [5:0] txw[$];
  logic [5:0] txs[$];
  logic [4:0] ctl;
  int         fail_count, comparisons, seed;

  pmhr_host_model h (.mclk_in(mclk_in), .rdata_in(rdat), .addr_out(a),
    .wdata_out(wd), .rd_n_out(rd_n), .wr_n_out(wr_n), .cs_n_out(cs_n));

  pmhr_top #(.SEC_CYCLES(10)) i_dut (.mclk_in(mclk_in), .nrst_in(nrst_in),
    .clk_en_in(1'b1), .address_in(a), .data_in(wd), .data_out(rdat),
    .data_oe_out(), .read_strobe_n_in(rd_n), .write_strobe_n_in(wr_n),
    .chip_select_n_in(cs_n), .interrupt_request_n_out(irq_n),
    .rx_sym_valid_in(rxv), .rx_sym_ready_out(rxr), .rx_sym_data_in(rxd),
    .sync_word_in(sw), .sync_err_count_in(sec), .bit_tick_in(tick),
    .decode_bit_valid_in(dv), .decode_fail_in(df),
    .idle_bit_valid_in(iv), .idle_bit_in(ib), .tx_sym_valid_out(txv),
    .tx_sym_ready_in(txr), .tx_sym_data_out(txd),
    .fast_acquire_out(ctl[4]), .rx_hold_out(ctl[3]),
    .receiver_powersave_out(ctl[2]), .transmitter_powersave_out(ctl[1]),
    .continuation_indicator_out(ctl[0]));

  ////////////////////////////////////////////////////////////////////////
  function automatic logic [5:0] gm(input logic [5:0] x, input logic [5:0] y);
    logic [5:0] p;
    p = 6'h00;
    for (int i = 0; i < 6; i++)
    begin
      if (y[i])
        p ^= x;
      x = {x[4:0], 1'b0} ^ (x[5] ? 6'h03 : 6'h00);
    end
    return p;
  endfunction : gm

  // codeword value at alpha^i, first symbol highest degree
  function automatic logic [5:0] syn(input int i, input logic [5:0] q[$]);
    logic [5:0] x;
    logic [5:0] s;
    x = 6'h01;
    s = 6'h00;
    for (int k = 0; k < i; k++)
      x = gm(x, 6'h02);
    foreach (q[k])
      s = gm(s, x) ^ q[k];
    return s;
  endfunction : syn

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : report_and_stop

  task automatic check(input string n, input logic [7:0] s,
                       input logic [7:0] e);
    comparisons++;
    if (s !== e)
    begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask : check

  task automatic guard(input int n, input int lim);
    if (n >= lim)
    begin
      fail_count++;
      report_and_stop();
    end
  endtask : guard

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_in);
    #1;
  endtask : cyc

  task automatic rchk(input logic [6:0] ad, input logic [7:0] e);
    logic [7:0] s;
    h.rd(ad, s);
    check($sformatf("reg %h", ad), s, e);
  endtask : rchk

  task automatic pulse(ref logic s);
    s = 1'b1;
    cyc(1);
    s = 1'b0;
    cyc(1);
  endtask : pulse

  task automatic push(input logic [5:0] d);
    rxv = 1'b1;
    rxd = d;
    for (int n = 0; !rxr; n++)
    begin
      guard(n, 100);
      cyc(1);
    end
    cyc(1);
  endtask : push

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    mclk_in = 1'b0;
    forever
      #5 mclk_in = ~mclk_in;
  end

  initial
  begin
    {nrst_in, rxv, sw, tick, dv, df, iv, ib, txr, err} = '0;
    rxd = 6'h00;
    sec = 3'd0;
    fail_count = 0;
    comparisons = 0;
    seed = 32'h81298805;
    cyc(16);
    nrst_in = 1'b1;
    check("control", {3'b000, ctl}, 8'h06);
    rchk(ADDR_STATUS, 8'h00);
    rchk(ADDR_FLAGS, 8'h00);
    rchk(7'h5a, 8'h00);
    $display("test reset end");
    h.wr(ADDR_CONTROL, 8'hd3);
    check("control", {3'b000, ctl}, 8'h1a);
    for (int i = 0; i < NUM_RX; i++)
      rxq.push_back(6'($random(seed)));
    foreach (rxq[i])
      push(rxq[i]);
    rxv = 1'b0;
    cyc(20);
    sec = 3'd2;
    pulse(sw);
    foreach (rxq[i])
      rchk(7'(i), {2'b00, rxq[i]});
    for (int i = 1; i <= NUM_SYN; i++)
    begin
      rchk(ADDR_SYN_BASE + 7'(i - 1), {2'b00, syn(i, rxq)});
      err |= syn(i, rxq) != 6'h00;
    end
    rchk(ADDR_STATUS, {3'b100, err, 4'h2});
    rchk(ADDR_FLAGS, 8'hb0);
    ib = 1'b1;
    for (int i = 1; i <= 3; i++)
    begin
      pulse(iv);
      rchk(ADDR_STATUS, {2'b10, i >= 3, err, 4'h2});
    end
    rchk(ADDR_FLAGS, 8'h20);
    df = 1'b1;
    h.wr(ADDR_MASK, 8'h40);
    pulse(dv);
    check("irq error", {7'h00, irq_n}, {7'h00, err});
    h.wr(ADDR_MASK, 8'h44);
    cyc(1);
    check("irq decode", {7'h00, irq_n}, 8'h00);
    rchk(ADDR_STATUS, {3'b111, err, 4'h2});
    rchk(ADDR_FLAGS, 8'h40);
    $display("test receive end");
    h.wr(ADDR_MASK, 8'h08);
    h.wr(ADDR_TIMER, 8'h02);
    cyc(8);
    check("irq early", {7'h00, irq_n}, 8'h01);
    cyc(14);
    check("irq", {7'h00, irq_n}, 8'h00);
    rchk(ADDR_FLAGS, 8'h08);
    cyc(3);
    check("irq free", {7'h00, irq_n}, 8'h01);
    h.wr(ADDR_MASK, 8'h00);
    h.wr(ADDR_TIMER, 8'h01);
    cyc(15);
    check("irq masked", {7'h00, irq_n}, 8'h01);
    rchk(ADDR_FLAGS, 8'h08);
    h.wr(ADDR_TIMER, 8'h00);
    cyc(30);
    rchk(ADDR_FLAGS, 8'h00);
    $display("test timer end");
    h.wr(ADDR_CONTROL, 8'h13);
    for (int i = 0; i < NUM_TX; i++)
    begin
      v = 8'($random(seed));
      txw.push_back(v[5:0]);
      h.wr(7'(i), v);
    end
    h.wr(ADDR_CONTROL, 8'h0b);
    check("control", {3'b000, ctl}, 8'h01);
    for (int n = 0; txs.size() < 2 * NUM_BLK; n++)
    begin
      guard(n, 2000);
      txr = 1'($random(seed));
      if (txv && txr)
        txs.push_back(txd);
      cyc(1);
    end
    h.wr(ADDR_CONTROL, 8'h13);
    foreach (txw[i])
      check("tx data", {2'b00, txs[i]}, {2'b00, txw[i]});
    for (int i = 1; i <= NUM_SYN; i++)
      check("parity", {2'b00, syn(i, txs[0:NUM_BLK-1])}, 8'h00);
    for (int i = 0; i < NUM_BLK; i++)
      check("resend", {2'b00, txs[i+NUM_BLK]}, {2'b00, txs[i]});
    rchk(ADDR_FLAGS, 8'h10);
    $display("test transmit end");
    repeat (NUM_RX)
      push(6'h00);
    rxv = 1'b0;
    cyc(20);
    v = 8'h00;
    rxv = 1'b1;
    for (int n = 0; rxr; n++)
    begin
      guard(n, 40);
      v++;
      cyc(1);
    end
    rxv = 1'b0;
    check("fifo fill", v, 8'(FIFO_DEPTH));
    sec = 3'd4;
    pulse(sw);
    rchk(ADDR_STATUS, {3'b111, err, 4'h2});
    sec = 3'd3;
    pulse(sw);
    for (int i = 0; i < NUM_RX; i++)
      rchk(7'(i), 8'h00);
    rchk(ADDR_STATUS, 8'he3);
    rchk(ADDR_FLAGS, 8'h80);
    repeat (SYNC_LOSS_BITS)
      pulse(tick);
    rchk(ADDR_STATUS, 8'he3);
    pulse(tick);
    rchk(ADDR_STATUS, 8'h63);
    rchk(ADDR_FLAGS, 8'h80);
    ib = 1'b0;
    repeat (5)
      pulse(iv);
    rchk(ADDR_STATUS, 8'h63);
    $display("test sync loss end");
    report_and_stop();
  end
endmodule : packet_modem_host_registers_tb

bind pmhr_top pmhr_properties #(.SEC_CYCLES(SEC_CYCLES)) i_props (
  .mclk_in(mclk_in), .nrst_in(nrst_in), .address_in(address_in),
  .data_in(data_in), .data_out(data_out), .data_oe_out(data_oe_out),
  .read_strobe_n_in(read_strobe_n_in),
  .write_strobe_n_in(write_strobe_n_in),
  .chip_select_n_in(chip_select_n_in),
  .interrupt_request_n_out(interrupt_request_n_out),
  .tx_sym_valid_out(tx_sym_valid_out), .tx_sym_ready_in(tx_sym_ready_in),
  .tx_sym_data_out(tx_sym_data_out),
  .transmitter_powersave_out(transmitter_powersave_out));

/* File: verification/pmhr_host_model.sv */
`timescale 1ns/1ps
module pmhr_host_model (
  input  wire logic       mclk_in,
  input  wire logic [7:0] rdata_in,
  output logic      [6:0] addr_out,
  output logic      [7:0] wdata_out,
  output logic            rd_n_out,
  output logic            wr_n_out,
  output logic            cs_n_out
);
  initial
  begin
    addr_out = 7'h00;
    wdata_out = 8'h00;
    rd_n_out = 1'b1;
    wr_n_out = 1'b1;
    cs_n_out = 1'b1;
  end

  // one write per strobe; strobe high for an edge between writes
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge mclk_in);
    #1;
    addr_out = a;
    wdata_out = d;
    cs_n_out = 1'b0;
    wr_n_out = 1'b0;
    @(posedge mclk_in);
    #1;
    cs_n_out = 1'b1;
    wr_n_out = 1'b1;
    wdata_out = ~d;
  endtask : wr

  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    @(posedge mclk_in);
    #1;
    addr_out = a;
    cs_n_out = 1'b0;
    rd_n_out = 1'b0;
    @(posedge mclk_in);
    #1;
    d = rdata_in;
    cs_n_out = 1'b1;
    rd_n_out = 1'b1;
  endtask : rd
endmodule : pmhr_host_model

/* File: verification/pmhr_properties.sv */
`timescale 1ns/1ps
module pmhr_properties
  import pmhr_pkg::*;
#(
  parameter int SEC_CYCLES = SECOND_CYCLES
) (
  input wire logic       mclk_in,
  input wire logic       nrst_in,
  input wire logic [6:0] address_in,
  input wire logic [7:0] data_in,
  input wire logic [7:0] data_out,
  input wire logic       data_oe_out,
  input wire logic       read_strobe_n_in,
  input wire logic       write_strobe_n_in,
  input wire logic       chip_select_n_in,
  input wire logic       interrupt_request_n_out,
  input wire logic       tx_sym_valid_out,
  input wire logic       tx_sym_ready_in,
  input wire logic [5:0] tx_sym_data_out,
  input wire logic       transmitter_powersave_out
);
  logic       rd_on;
  logic       wr_on;
  logic       wr_prev;
  logic [7:0] mask_seen;

  assign rd_on = !chip_select_n_in && !read_strobe_n_in;
  assign wr_on = !chip_select_n_in && !write_strobe_n_in;

  always_ff @(posedge mclk_in)
    wr_prev <= nrst_in && wr_on;

  // shadow of the mask register, loaded on the first edge of a write
  always_ff @(posedge mclk_in)
    if (!nrst_in)
      mask_seen <= MASK_RST;
    else if (wr_on && !wr_prev && address_in == ADDR_MASK)
      mask_seen <= data_in;

  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!nrst_in);

  sequence ctl_write;
    wr_on && !wr_prev && address_in == ADDR_CONTROL;
  endsequence

  sequence tx_stall;
    tx_sym_valid_out && !tx_sym_ready_in && !transmitter_powersave_out;
  endsequence

  oe_follows_a:
    assert property (data_oe_out == rd_on)
    else $error("read enable wrong");
  unmapped_zero_a:
    assert property (rd_on && address_in > ADDR_FLAGS |=> data_out == 8'h00)
    else $error("unmapped read not zero");
  upper_zero_a:
    assert property (rd_on && address_in < ADDR_STATUS
                     |=> data_out[7:6] == 2'b00)
    else $error("symbol upper bits set");
  read_holds_a:
    assert property (!rd_on |=> $stable(data_out))
    else $error("read data moved");
  tx_hold_a:
    assert property (tx_stall |=> transmitter_powersave_out
                     || (tx_sym_valid_out && $stable(tx_sym_data_out)))
    else $error("tx symbol dropped");
  tx_stop_a:
    assert property (transmitter_powersave_out |=> !tx_sym_valid_out)
    else $error("tx runs in powersave");
  control_load_a:
    assert property (ctl_write |=> transmitter_powersave_out
                     == $past(data_in[CT_TRANSMITTER_POWERSAVE]))
    else $error("control not loaded");
  mask_quiet_a:
    assert property (mask_seen[7:3] == 5'h00 |=> interrupt_request_n_out)
    else $error("masked interrupt");
endmodule : pmhr_properties
